/* verilog/cbu_map.svh */
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

// Opcode and offset fields of the 24-bit instruction word
`define CBU_OPC_HI          23
`define CBU_OPC_LO          16
`define CBU_OFS_HI          15
`define CBU_OFS_LO          0

// Upper opcode bytes
`define CBU_OPC_NEG         8'h33
`define CBU_OPC_NCARRY      8'h39
`define CBU_OPC_POSITIVE    8'h3B
`define CBU_OPC_NOVF        8'h38
`define CBU_OPC_NONZERO     8'h3A
`define CBU_OPC_ACC_A_OVF   8'h0C
`define CBU_OPC_ACC_B_OVF   8'h0D

// Cycles added by a taken branch on top of the single issue cycle
`define CBU_EXTRA_BASE      2'h1
`define CBU_EXTRA_ENH       2'h3

`endif

/* verilog/cbu_pkg.sv */
package cbu_pkg;

  typedef enum logic [2:0] {
    CBU_C_NONE,
    CBU_C_NEG,
    CBU_C_NCARRY,
    CBU_C_POSITIVE,
    CBU_C_NOVF,
    CBU_C_NONZERO,
    CBU_C_ACC_A_OVF,
    CBU_C_ACC_B_OVF
  } cbu_cond_t;

  typedef enum logic {
    CBU_IDLE,
    CBU_FLUSH
  } cbu_state_t;

endpackage : cbu_pkg

/* verilog/cbu_cond_eval.sv */
`timescale 1ns/1ps
`include "cbu_map.svh"

module cbu_cond_eval
  import cbu_pkg::*;
#(
  parameter bit HAS_DSP_ACC = 1'b1
)
(
  input  wire logic [7:0] opcode_i,
  input  wire logic       neg_flag_i,
  input  wire logic       carry_flag_i,
  input  wire logic       zero_flag_i,
  input  wire logic       overflow_flag_i,
  input  wire logic       acc_a_overflow_flag_i,
  input  wire logic       acc_b_overflow_flag_i,
  output logic            is_branch_o,
  output logic            taken_o
);

  function automatic cbu_cond_t decode_cond(input logic [7:0] opc);
    cbu_cond_t c;
    c = CBU_C_NONE;
    case (opc)
      `CBU_OPC_NEG:       c = CBU_C_NEG;
      `CBU_OPC_NCARRY:    c = CBU_C_NCARRY;
      `CBU_OPC_POSITIVE:  c = CBU_C_POSITIVE;
      `CBU_OPC_NOVF:      c = CBU_C_NOVF;
      `CBU_OPC_NONZERO:   c = CBU_C_NONZERO;
      // Accumulator branches are plain opcodes on cores without DSP
      `CBU_OPC_ACC_A_OVF: c = HAS_DSP_ACC ? CBU_C_ACC_A_OVF : CBU_C_NONE;
      `CBU_OPC_ACC_B_OVF: c = HAS_DSP_ACC ? CBU_C_ACC_B_OVF : CBU_C_NONE;
      default:            c = CBU_C_NONE;
    endcase
    return c;
  endfunction : decode_cond

  cbu_cond_t cond;

  always_comb
  begin
    cond        = decode_cond(opcode_i);
    is_branch_o = (cond != CBU_C_NONE);
    case (cond)
      CBU_C_NEG:       taken_o = neg_flag_i;
      CBU_C_NCARRY:    taken_o = !carry_flag_i;
      CBU_C_POSITIVE:  taken_o = !neg_flag_i;
      CBU_C_NOVF:      taken_o = !overflow_flag_i;
      CBU_C_NONZERO:   taken_o = !zero_flag_i;
      CBU_C_ACC_A_OVF: taken_o = acc_a_overflow_flag_i;
      CBU_C_ACC_B_OVF: taken_o = acc_b_overflow_flag_i;
      default:         taken_o = 1'b0;
    endcase
  end

endmodule : cbu_cond_eval

/* verilog/cbu_branch_unit.sv */
`timescale 1ns/1ps
`include "cbu_map.svh"
// Contract
// - Branch on negative when negative set
// - Branch on not carry when carry clear
// - Branch if positive when negative clear
// - Branch on no overflow when overflow clear
// - Branch if nonzero when zero clear
// - DSP: branch when accumulator A overflowed
// - Target is incremented PC plus twice offset
// - Low 16 bits are signed word offset
// - Taken branch replaces fetched instruction with NOP
// - Base core: one cycle, two if taken
// - Enhanced core: one cycle, four if taken

module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int PC_W         = 24,
  parameter bit HAS_DSP_ACC  = 1'b1,
  parameter bit ENHANCED     = 1'b0
)
(
  input  wire logic            CLK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic            INSTR_VALID_I,
  input  wire logic [23:0]     INSTR_I,
  input  wire logic [PC_W-1:0] PC_INC_I,
  input  wire logic            NEG_FLAG_I,
  input  wire logic            CARRY_FLAG_I,
  input  wire logic            ZERO_FLAG_I,
  input  wire logic            OVERFLOW_FLAG_I,
  input  wire logic            ACC_A_OVERFLOW_FLAG_I,
  input  wire logic            ACC_B_OVERFLOW_FLAG_I,
  output logic                 BRANCH_SEEN_O,
  output logic                 PC_LOAD_O,
  output logic [PC_W-1:0]      PC_TARGET_O,
  output logic                 NOP_INJECT_O,
  output logic                 BUSY_O
);

  localparam logic [1:0] EXTRA = ENHANCED ? `CBU_EXTRA_ENH : `CBU_EXTRA_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode

  logic is_branch;
  logic taken;
  logic accept;

  // Flags are inputs only; this block has no path back to the status word
  cbu_cond_eval #(
    .HAS_DSP_ACC (HAS_DSP_ACC)
  ) u_cond (
    .opcode_i              (INSTR_I[`CBU_OPC_HI:`CBU_OPC_LO]),
    .neg_flag_i            (NEG_FLAG_I),
    .carry_flag_i          (CARRY_FLAG_I),
    .zero_flag_i           (ZERO_FLAG_I),
    .overflow_flag_i       (OVERFLOW_FLAG_I),
    .acc_a_overflow_flag_i (ACC_A_OVERFLOW_FLAG_I),
    .acc_b_overflow_flag_i (ACC_B_OVERFLOW_FLAG_I),
    .is_branch_o           (is_branch),
    .taken_o               (taken)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Target arithmetic

  logic signed [15:0]  signed_branch_offset;
  logic [PC_W-1:0]     target;

  always_comb
  begin
    signed_branch_offset = INSTR_I[`CBU_OFS_HI:`CBU_OFS_LO];
    // Word offset doubled to bytes, sign carried up to the PC width
    target = PC_INC_I
           + PC_W'({{(PC_W-17){signed_branch_offset[15]}}, signed_branch_offset, 1'b0});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  cbu_state_t       state_reg, state_next;
  logic [1:0]       cnt_reg, cnt_next;
  logic             seen_reg, seen_next;
  logic             load_reg, load_next;
  logic [PC_W-1:0]  tgt_reg, tgt_next;
  logic             nop_reg, nop_next;
  logic             busy_reg, busy_next;

  // New instructions are ignored while the flush slots are running
  assign accept = INSTR_VALID_I && (state_reg == CBU_IDLE);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    seen_next  = accept && is_branch;
    load_next  = 1'b0;
    tgt_next   = tgt_reg;
    nop_next   = 1'b0;
    busy_next  = 1'b0;
    case (state_reg)
      CBU_IDLE:
      begin
        if (accept && is_branch && taken)
        begin
          state_next = CBU_FLUSH;
          cnt_next   = EXTRA - 2'h1;
          load_next  = 1'b1;
          tgt_next   = target;
          nop_next   = 1'b1;
          busy_next  = 1'b1;
        end
        // Not taken: PC_LOAD_O stays low, fetch carries on in order
      end
      CBU_FLUSH:
      begin
        if (cnt_reg == 2'h0)
        begin
          state_next = CBU_IDLE;
        end
        else
        begin
          cnt_next  = cnt_reg - 2'h1;
          nop_next  = 1'b1;
          busy_next = 1'b1;
        end
      end
      default:
      begin
        state_next = CBU_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg <= CBU_IDLE;
      cnt_reg   <= 2'h0;
      seen_reg  <= 1'b0;
      load_reg  <= 1'b0;
      tgt_reg   <= '0;
      nop_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      seen_reg  <= seen_next;
      load_reg  <= load_next;
      tgt_reg   <= tgt_next;
      nop_reg   <= nop_next;
      busy_reg  <= busy_next;
    end
  end

  assign BRANCH_SEEN_O = seen_reg;
  assign PC_LOAD_O     = load_reg;
  assign PC_TARGET_O   = tgt_reg;
  assign NOP_INJECT_O  = nop_reg;
  assign BUSY_O        = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_take;
    accept && is_branch && taken;
  endsequence

  sequence s_flush_run;
    PC_LOAD_O && NOP_INJECT_O && BUSY_O;
  endsequence

  a_neg_taken: assert property (
    accept && INSTR_I[23:16] == `CBU_OPC_NEG |=> PC_LOAD_O == $past(NEG_FLAG_I))
    else $error("negative branch decision wrong");

  a_ncarry_taken: assert property (
    accept && INSTR_I[23:16] == `CBU_OPC_NCARRY |=> PC_LOAD_O == !$past(CARRY_FLAG_I))
    else $error("not-carry branch decision wrong");

  a_pos_taken: assert property (
    accept && INSTR_I[23:16] == `CBU_OPC_POSITIVE |=> PC_LOAD_O == !$past(NEG_FLAG_I))
    else $error("positive branch decision wrong");

  a_novf_taken: assert property (
    accept && INSTR_I[23:16] == `CBU_OPC_NOVF |=> PC_LOAD_O == !$past(OVERFLOW_FLAG_I))
    else $error("no-overflow branch decision wrong");

  a_nz_taken: assert property (
    accept && INSTR_I[23:16] == `CBU_OPC_NONZERO |=> PC_LOAD_O == !$past(ZERO_FLAG_I))
    else $error("nonzero branch decision wrong");

  a_acca_taken: assert property (
    accept && HAS_DSP_ACC && INSTR_I[23:16] == `CBU_OPC_ACC_A_OVF
    |=> PC_LOAD_O == $past(ACC_A_OVERFLOW_FLAG_I))
    else $error("accumulator A branch decision wrong");

  a_accb_taken: assert property (
    accept && HAS_DSP_ACC && INSTR_I[23:16] == `CBU_OPC_ACC_B_OVF
    |=> PC_LOAD_O == $past(ACC_B_OVERFLOW_FLAG_I))
    else $error("accumulator B branch decision wrong");

  a_target_math: assert property (
    s_take |=> PC_TARGET_O ==
      PC_W'($past(PC_INC_I) + PC_W'(2 * $signed($past(INSTR_I[15:0])))))
    else $error("branch target wrong");

  a_base_length: assert property (
    s_take and (!ENHANCED) |=> s_flush_run ##1 !BUSY_O && !NOP_INJECT_O)
    else $error("base taken branch length wrong");

  a_enh_length: assert property (
    s_take and (ENHANCED) |=> s_flush_run ##1 (BUSY_O && NOP_INJECT_O && !PC_LOAD_O) [*2]
    ##1 !BUSY_O)
    else $error("enhanced taken branch length wrong");

  a_nop_pairs: assert property (
    PC_LOAD_O |-> NOP_INJECT_O && $past(state_reg) == CBU_IDLE)
    else $error("taken branch without NOP");

  a_not_taken: assert property (
    accept && !(is_branch && taken) |=> !PC_LOAD_O && !NOP_INJECT_O && !BUSY_O)
    else $error("flush on sequential path");

endmodule : cbu_branch_unit

/* tb/cbu_pipe_model.sv */
`timescale 1ns/1ps
// Fetch side: counts the NOP slots that replace fetched words
module cbu_pipe_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       nop_i,
  output logic      [7:0] nops_o
);
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      nops_o <= 8'h00;
    else
      nops_o <= nops_o + {7'h00, nop_i};
  end
endmodule : cbu_pipe_model

/* tb/conditional_branch_unit_test.sv */
`timescale 1ns/1ps
module conditional_branch_unit_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic [23:0] ins = 24'h000000;
  logic [23:0] pc  = 24'h002002;
  logic [5:0]  f   = 6'h00;
  logic        sn, ld, np, bz, sn_e, ld_e, np_e, bz_e;
  logic [23:0] tg, tg_e;
  logic [7:0]  nops;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [7:0]  ops [7] = '{8'h33, 8'h39, 8'h3B, 8'h38, 8'h3A, 8'h0C, 8'h0D};

  always #5 clk = ~clk;

  cbu_branch_unit #(.HAS_DSP_ACC(1'b1), .ENHANCED(1'b0)) DUT (.CLK_I(clk),
    .SYS_RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins), .PC_INC_I(pc),
    .NEG_FLAG_I(f[0]), .CARRY_FLAG_I(f[1]), .ZERO_FLAG_I(f[2]),
    .OVERFLOW_FLAG_I(f[3]), .ACC_A_OVERFLOW_FLAG_I(f[4]),
    .ACC_B_OVERFLOW_FLAG_I(f[5]), .BRANCH_SEEN_O(sn), .PC_LOAD_O(ld),
    .PC_TARGET_O(tg), .NOP_INJECT_O(np), .BUSY_O(bz));
  // Enhanced core without accumulators, fed the same stream
  cbu_branch_unit #(.HAS_DSP_ACC(1'b0), .ENHANCED(1'b1)) DUT_E (.CLK_I(clk),
    .SYS_RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins), .PC_INC_I(pc),
    .NEG_FLAG_I(f[0]), .CARRY_FLAG_I(f[1]), .ZERO_FLAG_I(f[2]),
    .OVERFLOW_FLAG_I(f[3]), .ACC_A_OVERFLOW_FLAG_I(f[4]),
    .ACC_B_OVERFLOW_FLAG_I(f[5]), .BRANCH_SEEN_O(sn_e), .PC_LOAD_O(ld_e),
    .PC_TARGET_O(tg_e), .NOP_INJECT_O(np_e), .BUSY_O(bz_e));
  cbu_pipe_model PIPE (.clk_i(clk), .rst_i(rst), .nop_i(np_e), .nops_o(nops));

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One instruction for one cycle; returns once its answer is settled
  task automatic issue(input logic [7:0] op, input logic [5:0] fl,
                       input logic [15:0] ofs);
    @(negedge clk);
    vld = 1'b1;
    ins = {op, ofs};
    f   = fl;
    @(negedge clk);
    vld = 1'b0;
  endtask : issue

  function automatic logic tk(input logic [7:0] op, input logic [5:0] fl);
    case (op)
      8'h33:   return fl[0];
      8'h39:   return !fl[1];
      8'h3B:   return !fl[0];
      8'h38:   return !fl[3];
      8'h3A:   return !fl[2];
      8'h0C:   return fl[4];
      8'h0D:   return fl[5];
      default: return 1'b0;
    endcase
  endfunction : tk

  //////////////////////////////////////////////////////////////////////
  task automatic t_conds;
    logic [5:0] fl;
    for (int i = 0; i < 7; i++)
      for (int k = 0; k < 2; k++)
      begin
        fl = k ? 6'h3F : 6'h00;
        issue(ops[i], fl, 16'h0005);
        chk(sn, 1'b1);
        chk(ld, tk(ops[i], fl));
        chk(np, tk(ops[i], fl));
        chk(sn_e, i < 5);
        repeat (4) @(negedge clk);
      end
    issue(8'h00, 6'h00, 16'h0005);
    chk(sn, 1'b0);
    chk(ld | np, 1'b0);
  endtask : t_conds

  // Offset extremes: word count doubled and sign extended
  task automatic t_offset;
    logic [15:0] o [3] = '{16'h8000, 16'h7FFF, 16'h0005};
    for (int i = 0; i < 3; i++)
    begin
      issue(8'h33, 6'h01, o[i]);
      chk(tg, pc + {{7{o[i][15]}}, o[i], 1'b0});
      chk(tg_e, pc + {{7{o[i][15]}}, o[i], 1'b0});
      repeat (4) @(negedge clk);
    end
  endtask : t_offset

  task automatic t_timing;
    logic [7:0] n0;
    n0 = nops;
    issue(8'h33, 6'h01, 16'h0005);
    chk(bz, 1'b1);
    chk(bz_e, 1'b1);
    @(negedge clk);
    chk(bz, 1'b0);
    chk(ld_e, 1'b0);
    repeat (2) @(negedge clk);
    chk(bz_e, 1'b0);
    chk(nops - n0, 8'h03);
  endtask : t_timing

  // Back to back untaken, then a branch offered while flushing
  task automatic t_b2b;
    @(negedge clk);
    vld = 1'b1;
    ins = {8'h3A, 16'h0005};
    f   = 6'h04;
    @(negedge clk);
    ins = {8'h3B, 16'h0005};
    f   = 6'h01;
    chk(sn, 1'b1);
    chk(ld | np, 1'b0);
    @(negedge clk);
    chk(sn, 1'b1);
    chk(ld | np | bz, 1'b0);
    ins = {8'h33, 16'h0001};
    @(negedge clk);
    ins = {8'h33, 16'h0010};
    @(negedge clk);
    vld = 1'b0;
    chk(ld, 1'b0);
    chk(tg, 24'h002004);
  endtask : t_b2b

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_conds();
    t_offset();
    t_timing();
    t_b2b();
    summarize();
  end
endmodule : conditional_branch_unit_test
